/* File: hbtu_regs.svh */
// Register offsets, field positions, reset values and fixed codes of the breakpoint trigger unit
`ifndef HBTU_REGS_SVH
`define HBTU_REGS_SVH

// ----------------------------------------------------------------
// Control register addresses
// ----------------------------------------------------------------
`define HBTU_CSR_SELECT 12'h7a0
`define HBTU_CSR_DATA1 12'h7a1
`define HBTU_CSR_DATA2 12'h7a2
`define HBTU_CSR_DATA3 12'h7a3

// ----------------------------------------------------------------
// Match control fields
// ----------------------------------------------------------------
`define HBTU_F_LOAD 0
`define HBTU_F_STORE 1
`define HBTU_F_FETCH 2
`define HBTU_F_USER 3
`define HBTU_F_SUPER 4
`define HBTU_F_MACH 6
`define HBTU_F_MATCH_LO 7
`define HBTU_F_MATCH_HI 10
`define HBTU_F_CHAIN 11
`define HBTU_F_ACTION_LO 12
`define HBTU_F_ACTION_HI 17
`define HBTU_F_OWNER 27
`define HBTU_TYPE_ADDR 4'h2
`define HBTU_TYPE_NONE 4'h0
`define HBTU_MASKMAX 6'h04
`define HBTU_MATCH_EXACT 4'h0
`define HBTU_MATCH_POW2 4'h1
`define HBTU_MATCH_GE 4'h2
`define HBTU_MATCH_LT 4'h3
`define HBTU_ACTION_EXC 6'h00
`define HBTU_ACTION_DEBUG 6'h01
`define HBTU_NUM_TRIG 4
`define HBTU_RST_SELECT 2'h0

// ----------------------------------------------------------------
// Debug module memory and abstract access
// ----------------------------------------------------------------
`define HBTU_DM_ZERO 12'h000
`define HBTU_DM_PB_BASE 12'h300
`define HBTU_DM_PB_WORDS 16
`define HBTU_DM_DATA_ADDR 12'h340
`define HBTU_DM_RAM_WORDS 17
`define HBTU_ABS_GPR_FIRST 16'h1000
`define HBTU_ABS_GPR_LAST 16'h101f
`define HBTU_CAUSE_BREAK 4'h3

`endif

/* File: hbtu_pkg.sv */
// Types shared by the breakpoint trigger unit
`default_nettype none
package hbtu_pkg;
	typedef enum logic [1:0] {HBTU_LOAD, HBTU_STORE, HBTU_FETCH} hbtu_kind_e;

	typedef struct packed {
		logic valid;
		logic write;
		logic [11:0] addr;
		logic [31:0] wdata;
	} hbtu_csr_req_s;

	typedef struct packed {
		logic valid;
		hbtu_kind_e kind;
		logic [1:0] priv;
		logic [1:0] size_m1;
		logic [31:0] addr;
	} hbtu_acc_req_s;

	typedef struct packed {
		logic valid;
		logic write;
		logic from_debug;
		logic [11:0] addr;
		logic [31:0] wdata;
	} hbtu_dm_req_s;

	typedef struct packed {
		logic valid;
		logic write;
		logic [15:0] regno;
	} hbtu_abs_cmd_s;

	typedef struct packed {
		logic owner;
		logic action;
		logic chain;
		logic [3:0] match;
		logic mach;
		logic supv;
		logic user;
		logic fetch;
		logic store;
		logic load;
	} hbtu_trig_cfg_s;
endpackage : hbtu_pkg
`default_nettype wire

/* File: hbtu_trig.sv */
// One address comparator of the breakpoint trigger unit
`timescale 1ns/1ps
`default_nettype none
`include "hbtu_regs.svh"
module hbtu_trig
(
	input wire hbtu_pkg::hbtu_trig_cfg_s cfg,
	input wire logic [31:0] tval,
	input wire hbtu_pkg::hbtu_acc_req_s acc,
	input wire logic [31:0] last_byte,
	output logic hit
);
	import hbtu_pkg::*;

	// ----------------------------------------------------------------
	// Access kind and privilege filter
	// ----------------------------------------------------------------
	wire kind_ok = (acc.kind == HBTU_LOAD && cfg.load) || (acc.kind == HBTU_STORE && cfg.store) ||
		(acc.kind == HBTU_FETCH && cfg.fetch); // R5
	wire priv_ok = (acc.priv == 2'h3 && cfg.mach) || (acc.priv == 2'h1 && cfg.supv) ||
		(acc.priv == 2'h0 && cfg.user); // R6

	// ----------------------------------------------------------------
	// Range decode and overlap
	// ----------------------------------------------------------------
	wire [31:0] pow2_mask = tval ^ (tval + 32'h0000_0001); // R8 R9
	wire [31:0] mask = (cfg.match == `HBTU_MATCH_POW2) ? pow2_mask : 32'h0000_0000;
	wire [31:0] base = tval & ~mask; // R8
	wire [31:0] top = tval | mask;
	wire overlap = (acc.addr <= top) && (last_byte >= base); // R12
	wire ge_ok = last_byte >= tval; // R10
	wire lt_ok = acc.addr < tval; // R10
	wire addr_ok = (cfg.match == `HBTU_MATCH_GE) ? ge_ok : (cfg.match == `HBTU_MATCH_LT) ? lt_ok : overlap; // R7

	assign hit = acc.valid && kind_ok && priv_ok && addr_ok;
endmodule : hbtu_trig
`default_nettype wire

/* File: hbtu_top.sv */
// Breakpoint trigger unit with its debug module memory region
//
// Overview of operation
// [R1] Control reports largest power-of-two range as four
// [R2] Owner bit 27 reserves trigger for debug
// [R3] Top control nibble reads two, address match
// [R4] Action zero traps, one enters debug mode
// [R5] Load, store, fetch enables in any combination
// [R6] Machine, supervisor, user enables in any combination
// [R7] Match field picks exact, aligned, chained range
// [R8] Trailing ones of address encode range size
// [R9] Thirty ones then zero compares bit 31
// [R10] Greater-equal and less-than pair via chain
// [R11] Address register full width read write
// [R12] Precise trap when any accessed byte matches
// [R13] Debug entry keeps machine state untouched
// [R14] Machine trap records cause and bad address
// [R15] Debug-owned trigger reads type zero in machine
// [R16] Sixteen-word program buffer at 0x300
// [R17] One data word follows, plain read write
// [R18] Abstract access only for halted general registers
// [R19] Hart reset status bits not implemented
// [R20] Address zero reads zero, ignores writes
// [R21] Memory reachable only from debug or transport
// [R22] Debugger code touches only buffer and data
// [R23] Four triggers chosen through select register
// [R24] Machine access to owned trigger is illegal
// [R25] Chain bit 11 links to next trigger
// [R26] Unsupported field writes become legal values
`timescale 1ns/1ps
`default_nettype none
`include "hbtu_regs.svh"
module hbtu_top
(
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic dbg_mode,
	input wire logic hart_halted,
	input wire hbtu_pkg::hbtu_csr_req_s csr_req,
	output logic csr_ack_ff,
	output logic csr_illegal_ff,
	output logic [31:0] csr_rdata_ff,
	input wire hbtu_pkg::hbtu_acc_req_s acc_req,
	output logic trap_valid_ff,
	output logic trap_debug_ff,
	output logic trap_mexc_ff,
	output logic trap_mstate_we_ff,
	output logic [3:0] trap_cause_ff,
	output logic [31:0] trap_badaddr_ff,
	input wire hbtu_pkg::hbtu_dm_req_s dm_req,
	output logic dm_ack_ff,
	output logic dm_err_ff,
	output logic [31:0] dm_rdata_ff,
	input wire hbtu_pkg::hbtu_abs_cmd_s abs_cmd,
	input wire logic gpr_rvalid,
	input wire logic [31:0] gpr_rdata,
	output logic abs_ok_ff,
	output logic abs_err_ff,
	output logic gpr_req_ff,
	output logic gpr_write_ff,
	output logic [4:0] gpr_idx_ff,
	output logic [31:0] gpr_wdata_ff,
	output logic some_hart_was_reset_ff,
	output logic every_hart_was_reset_ff
);
	import hbtu_pkg::*;

	// ----------------------------------------------------------------
	// Trigger storage
	// ----------------------------------------------------------------
	hbtu_trig_cfg_s cfg_ff [`HBTU_NUM_TRIG];
	logic [31:0] tval_ff [`HBTU_NUM_TRIG];
	logic [1:0] sel_ff;
	logic [31:0] ram_ff [`HBTU_DM_RAM_WORDS];
	logic [`HBTU_NUM_TRIG-1:0] hit;
	logic [`HBTU_NUM_TRIG-1:0] fire;

	// ----------------------------------------------------------------
	// Control register decode
	// ----------------------------------------------------------------
	wire is_sel = csr_req.addr == `HBTU_CSR_SELECT;
	wire is_d1 = csr_req.addr == `HBTU_CSR_DATA1;
	wire is_d2 = csr_req.addr == `HBTU_CSR_DATA2;
	wire is_d3 = csr_req.addr == `HBTU_CSR_DATA3;
	wire csr_hit = csr_req.valid && (is_sel || is_d1 || is_d2 || is_d3);
	hbtu_trig_cfg_s cur_cfg;
	assign cur_cfg = cfg_ff[sel_ff];
	wire hidden = cur_cfg.owner && !dbg_mode; // R15 R24
	wire data_illegal = hidden && (is_d1 || is_d2 || is_d3); // R24
	wire data_wr = csr_hit && csr_req.write && !data_illegal;
	wire [31:0] d1_view = {`HBTU_TYPE_ADDR, cur_cfg.owner, `HBTU_MASKMAX, 3'h0, 5'h00, cur_cfg.action,
		cur_cfg.chain, cur_cfg.match, cur_cfg.mach, 1'b0, cur_cfg.supv, cur_cfg.user,
		cur_cfg.fetch, cur_cfg.store, cur_cfg.load}; // R1 R2 R3 R25
	wire [31:0] nxt_csr_rdata = data_illegal ? 32'h0000_0000 : // R15
		is_sel ? {30'h0000_0000, sel_ff} :
		is_d1 ? d1_view :
		is_d2 ? tval_ff[sel_ff] : 32'h0000_0000;

	// ----------------------------------------------------------------
	// Legalised write value for the selected match control
	// ----------------------------------------------------------------
	wire [3:0] wr_match = csr_req.wdata[`HBTU_F_MATCH_HI:`HBTU_F_MATCH_LO];
	wire [5:0] wr_action = csr_req.wdata[`HBTU_F_ACTION_HI:`HBTU_F_ACTION_LO];
	hbtu_trig_cfg_s wr_cfg;
	assign wr_cfg.owner = dbg_mode ? csr_req.wdata[`HBTU_F_OWNER] : cur_cfg.owner; // R2
	assign wr_cfg.action = wr_action == `HBTU_ACTION_DEBUG; // R4 R26
	assign wr_cfg.chain = csr_req.wdata[`HBTU_F_CHAIN] && (sel_ff != 2'h3); // R25 R26
	assign wr_cfg.match = (wr_match <= `HBTU_MATCH_LT) ? wr_match : `HBTU_MATCH_EXACT; // R7 R26
	assign wr_cfg.mach = csr_req.wdata[`HBTU_F_MACH];
	assign wr_cfg.supv = csr_req.wdata[`HBTU_F_SUPER];
	assign wr_cfg.user = csr_req.wdata[`HBTU_F_USER];
	assign wr_cfg.fetch = csr_req.wdata[`HBTU_F_FETCH];
	assign wr_cfg.store = csr_req.wdata[`HBTU_F_STORE];
	assign wr_cfg.load = csr_req.wdata[`HBTU_F_LOAD];

	always_ff @(posedge clk_sys)
	begin
		if (rst)
			sel_ff <= `HBTU_RST_SELECT;
		else if (data_wr && is_sel && csr_req.wdata < 32'h0000_0004)
			sel_ff <= csr_req.wdata[1:0]; // R23 R26
	end

	always_ff @(posedge clk_sys)
	begin
		if (rst)
		begin
			csr_ack_ff <= 1'b0;
			csr_illegal_ff <= 1'b0;
			csr_rdata_ff <= 32'h0000_0000;
		end
		else
		begin
			csr_ack_ff <= csr_hit;
			csr_illegal_ff <= csr_hit && data_illegal; // R24
			csr_rdata_ff <= csr_hit ? nxt_csr_rdata : 32'h0000_0000;
		end
	end

	// ----------------------------------------------------------------
	// Per-trigger registers and comparators
	// ----------------------------------------------------------------
	wire [31:0] last_byte = acc_req.addr + {30'h0000_0000, acc_req.size_m1};

	genvar gi;
	generate
		for (gi = 0; gi < `HBTU_NUM_TRIG; gi++)
		begin : g_trig
			wire sel_me = sel_ff == 2'(gi);
			always_ff @(posedge clk_sys)
			begin
				if (rst)
				begin
					cfg_ff[gi] <= '0;
					tval_ff[gi] <= 32'h0000_0000;
				end
				else if (data_wr && sel_me && is_d1)
					cfg_ff[gi] <= wr_cfg;
				else if (data_wr && sel_me && is_d2)
					tval_ff[gi] <= csr_req.wdata; // R11
			end
			hbtu_trig u_trig
			(
				.cfg(cfg_ff[gi]),
				.tval(tval_ff[gi]),
				.acc(acc_req),
				.last_byte(last_byte),
				.hit(hit[gi])
			);
			if (gi == 0)
			begin : g_first
				assign fire[gi] = hit[gi] && !cfg_ff[gi].chain;
			end
			else
			begin : g_rest
				assign fire[gi] = hit[gi] && !cfg_ff[gi].chain && (!cfg_ff[gi-1].chain || hit[gi-1]); // R10 R25
			end
		end
	endgenerate

	// ----------------------------------------------------------------
	// Trap selection, lowest firing trigger wins
	// ----------------------------------------------------------------
	wire any_fire = |fire && !dbg_mode;
	wire win_debug = fire[0] ? cfg_ff[0].action : fire[1] ? cfg_ff[1].action :
		fire[2] ? cfg_ff[2].action : cfg_ff[3].action; // R4

	always_ff @(posedge clk_sys)
	begin
		if (rst)
		begin
			trap_valid_ff <= 1'b0;
			trap_debug_ff <= 1'b0;
			trap_mexc_ff <= 1'b0;
			trap_mstate_we_ff <= 1'b0;
			trap_cause_ff <= 4'h0;
			trap_badaddr_ff <= 32'h0000_0000;
		end
		else
		begin
			trap_valid_ff <= any_fire; // R12
			trap_debug_ff <= any_fire && win_debug; // R13
			trap_mexc_ff <= any_fire && !win_debug;
			trap_mstate_we_ff <= any_fire && !win_debug; // R13 R14
			trap_cause_ff <= (any_fire && !win_debug) ? `HBTU_CAUSE_BREAK : 4'h0; // R14
			trap_badaddr_ff <= (any_fire && !win_debug) ? acc_req.addr : 32'h0000_0000; // R14
		end
	end

	// ----------------------------------------------------------------
	// Debug module memory
	// ----------------------------------------------------------------
	wire dm_ok = dm_req.valid && dm_req.from_debug; // R21
	wire in_ram = dm_req.addr >= `HBTU_DM_PB_BASE && dm_req.addr <= `HBTU_DM_DATA_ADDR; // R16 R17
	wire [11:0] ram_off = dm_req.addr - `HBTU_DM_PB_BASE;
	wire [4:0] ram_idx = ram_off[6:2];
	wire [31:0] nxt_dm_rdata = (dm_ok && !dm_req.write && in_ram) ? ram_ff[ram_idx] : 32'h0000_0000; // R20

	always_ff @(posedge clk_sys)
	begin
		if (gpr_rvalid)
			ram_ff[`HBTU_DM_PB_WORDS] <= gpr_rdata; // R18
		else if (dm_ok && dm_req.write && in_ram)
			ram_ff[ram_idx] <= dm_req.wdata; // R16 R17
	end

	always_ff @(posedge clk_sys)
	begin
		if (rst)
		begin
			dm_ack_ff <= 1'b0;
			dm_err_ff <= 1'b0;
			dm_rdata_ff <= 32'h0000_0000;
		end
		else
		begin
			dm_ack_ff <= dm_req.valid;
			dm_err_ff <= dm_req.valid && !dm_req.from_debug; // R21
			dm_rdata_ff <= nxt_dm_rdata;
		end
	end

	// ----------------------------------------------------------------
	// Abstract register access and hart status
	// ----------------------------------------------------------------
	wire abs_gpr = abs_cmd.regno >= `HBTU_ABS_GPR_FIRST && abs_cmd.regno <= `HBTU_ABS_GPR_LAST;
	wire abs_take = abs_cmd.valid && abs_gpr && hart_halted; // R18

	always_ff @(posedge clk_sys)
	begin
		if (rst)
		begin
			abs_ok_ff <= 1'b0;
			abs_err_ff <= 1'b0;
			gpr_req_ff <= 1'b0;
			gpr_write_ff <= 1'b0;
			gpr_idx_ff <= 5'h00;
			gpr_wdata_ff <= 32'h0000_0000;
			some_hart_was_reset_ff <= 1'b0;
			every_hart_was_reset_ff <= 1'b0;
		end
		else
		begin
			abs_ok_ff <= abs_take;
			abs_err_ff <= abs_cmd.valid && !abs_take; // R18
			gpr_req_ff <= abs_take;
			gpr_write_ff <= abs_take && abs_cmd.write;
			gpr_idx_ff <= abs_take ? abs_cmd.regno[4:0] : 5'h00;
			gpr_wdata_ff <= abs_take ? ram_ff[`HBTU_DM_PB_WORDS] : 32'h0000_0000;
			some_hart_was_reset_ff <= 1'b0; // R19
			every_hart_was_reset_ff <= 1'b0; // R19
		end
	end

	// ----------------------------------------------------------------
	// Assertions and covers
	// ----------------------------------------------------------------
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (rst);

	AST_DATA1_FIXED: assert property ($past(csr_hit && is_d1 && !data_illegal) |-> // R1 R3
		csr_rdata_ff[31:28] == 4'h2 && csr_rdata_ff[26:21] == 6'h04)
		else $error("fixed fields of match control wrong");
	AST_HIDE_OWNED: assert property (csr_ack_ff && csr_illegal_ff |-> csr_rdata_ff == 32'h0000_0000) // R15
		else $error("owned trigger visible to machine mode");
	AST_OWNED_ILLEGAL: assert property (csr_req.valid && is_d2 && cur_cfg.owner && !dbg_mode |=> // R24
		csr_ack_ff && csr_illegal_ff)
		else $error("machine access to owned trigger not illegal");
	AST_ONE_ACTION: assert property (trap_valid_ff |-> trap_debug_ff != trap_mexc_ff) // R4
		else $error("trap takes both or no action");
	AST_DEBUG_KEEPS_M: assert property (trap_debug_ff |-> !trap_mstate_we_ff && trap_cause_ff == 4'h0) // R13
		else $error("debug entry touched machine state");
	AST_BREAK_RECORD: assert property (trap_mexc_ff |-> trap_cause_ff == 4'h3 && // R14
		trap_badaddr_ff == $past(acc_req.addr))
		else $error("breakpoint cause or bad address wrong");
	AST_ZERO_ADDR: assert property (dm_ok && dm_req.addr == 12'h000 |=> dm_rdata_ff == 32'h0000_0000) // R20
		else $error("address zero returned data");
	AST_DM_GUARD: assert property (dm_req.valid && !dm_req.from_debug |=> dm_err_ff && // R21
		dm_rdata_ff == 32'h0000_0000)
		else $error("debug memory reached from outside debug");
	AST_PB_READBACK: assert property (dm_ok && dm_req.write && in_ram && ram_idx < 5'h10 ##1 // R16
		dm_ok && !dm_req.write && dm_req.addr == $past(dm_req.addr) |=> dm_rdata_ff == $past(dm_req.wdata, 2))
		else $error("program buffer lost a write");
	AST_SELECT_LEGAL: assert property ($past(csr_hit && is_sel) |-> csr_rdata_ff < 32'h0000_0004) // R23 R26
		else $error("select holds an unimplemented index");
	AST_ABS_HALTED: assert property (abs_cmd.valid && !hart_halted |=> abs_err_ff && !gpr_req_ff) // R18
		else $error("abstract access accepted on running hart");
	AST_NO_RESET_STATUS: assert property (##1 !some_hart_was_reset_ff && !every_hart_was_reset_ff) // R19
		else $error("hart reset status bit set");

	COV_DEBUG_TRAP: cover property (trap_debug_ff);
	COV_BREAK_TRAP: cover property (trap_mexc_ff);
	COV_CHAIN_FIRE: cover property (acc_req.valid && hit[0] && cfg_ff[0].chain && fire[1]);
	COV_ABS_OK: cover property (abs_ok_ff && gpr_write_ff);
endmodule : hbtu_top
`default_nettype wire

/* File: hbtu_core_model.sv */
// Core-side model that hands general register values back to the trigger unit
`timescale 1ns/1ps
`default_nettype none
module hbtu_core_model
#(
	parameter int LAT = 3
)
(
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic gpr_req,
	input wire logic gpr_write,
	input wire logic [4:0] gpr_idx,
	output logic gpr_rvalid,
	output logic [31:0] gpr_rdata
);
	int cnt;
	logic [4:0] idx;
	wire answer = cnt == 1 && !(gpr_req && !gpr_write);
	// Data line shows a changing pattern outside the answer cycle
	always @(posedge clk_sys)
	begin
		if (rst)
		begin
			cnt <= 0;
			gpr_rvalid <= 1'b0;
			gpr_rdata <= 32'h5a5a_5a5a;
		end
		else
		begin
			gpr_rvalid <= answer;
			gpr_rdata <= answer ? {16'hc0de, 11'h000, idx} : ~gpr_rdata;
			if (gpr_req && !gpr_write)
			begin
				cnt <= LAT;
				idx <= gpr_idx;
			end
			else if (cnt > 0)
				cnt <= cnt - 1;
		end
	end
endmodule : hbtu_core_model
`default_nettype wire

/* File: hbtu_top_tb.sv */
// Self-checking bench of the breakpoint trigger unit
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin n_errors++; $display("ERROR t=%0t got=%h exp=%h", $time, g, e); end end
module hbtu_top_tb;
	import hbtu_pkg::*;
	logic clk_sys = 1'b0;
	logic rst = 1'b1;
	logic dbg_mode = 1'b0;
	logic hart_halted = 1'b0;
	hbtu_csr_req_s csr_req = '0;
	hbtu_acc_req_s acc_req = '0;
	hbtu_dm_req_s dm_req = '0;
	hbtu_abs_cmd_s abs_cmd = '0;
	logic csr_ack_ff, csr_illegal_ff, trap_valid_ff, trap_debug_ff, trap_mexc_ff, trap_mstate_we_ff;
	logic dm_ack_ff, dm_err_ff, abs_ok_ff, abs_err_ff, gpr_req_ff, gpr_write_ff, gpr_rvalid;
	logic some_hart_was_reset_ff, every_hart_was_reset_ff;
	logic [3:0] trap_cause_ff;
	logic [4:0] gpr_idx_ff;
	logic [31:0] csr_rdata_ff, trap_badaddr_ff, dm_rdata_ff, gpr_rdata, gpr_wdata_ff;
	logic [33:0] cr, dr;
	logic [39:0] tr;
	logic [40:0] ar;
	int n_errors = 0;
	int checked = 0;

	always #5 clk_sys = ~clk_sys;

	hbtu_top i_dut (.clk_sys, .rst, .dbg_mode, .hart_halted, .csr_req, .csr_ack_ff, .csr_illegal_ff,
		.csr_rdata_ff, .acc_req, .trap_valid_ff, .trap_debug_ff, .trap_mexc_ff, .trap_mstate_we_ff,
		.trap_cause_ff, .trap_badaddr_ff, .dm_req, .dm_ack_ff, .dm_err_ff, .dm_rdata_ff, .abs_cmd,
		.gpr_rvalid, .gpr_rdata, .abs_ok_ff, .abs_err_ff, .gpr_req_ff, .gpr_write_ff, .gpr_idx_ff,
		.gpr_wdata_ff, .some_hart_was_reset_ff, .every_hart_was_reset_ff);

	hbtu_core_model #(.LAT(3)) i_core (.clk_sys, .rst, .gpr_req(gpr_req_ff), .gpr_write(gpr_write_ff),
		.gpr_idx(gpr_idx_ff), .gpr_rvalid, .gpr_rdata);

	// ------------------------------------------------
	// Bus tasks
	// ------------------------------------------------
	task automatic csr(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge clk_sys);
		csr_req <= '{1'b1, w, a, d};
		@(posedge clk_sys);
		csr_req.valid <= 1'b0;
		#1 cr = {csr_ack_ff, csr_illegal_ff, csr_rdata_ff};
	endtask : csr

	task automatic cfg(input logic [1:0] t, input logic [31:0] d1, input logic [31:0] d2);
		csr(1'b1, 12'h7a0, {30'h0, t});
		csr(1'b1, 12'h7a1, d1);
		csr(1'b1, 12'h7a2, d2);
	endtask : cfg

	task automatic acc(input hbtu_kind_e k, input logic [1:0] p, input logic [1:0] s, input logic [31:0] a);
		@(posedge clk_sys);
		acc_req <= '{1'b1, k, p, s, a};
		@(posedge clk_sys);
		acc_req.valid <= 1'b0;
		#1 tr = {trap_valid_ff, trap_debug_ff, trap_mexc_ff, trap_mstate_we_ff, trap_cause_ff, trap_badaddr_ff};
	endtask : acc

	task automatic dm(input logic w, input logic fd, input logic [11:0] a, input logic [31:0] d);
		@(posedge clk_sys);
		dm_req <= '{1'b1, w, fd, a, d};
		@(posedge clk_sys);
		dm_req.valid <= 1'b0;
		#1 dr = {dm_ack_ff, dm_err_ff, dm_rdata_ff};
	endtask : dm

	task automatic ab(input logic w, input logic [15:0] r);
		@(posedge clk_sys);
		abs_cmd <= '{1'b1, w, r};
		@(posedge clk_sys);
		abs_cmd.valid <= 1'b0;
		#1 ar = {abs_ok_ff, abs_err_ff, gpr_req_ff, gpr_write_ff, gpr_idx_ff, gpr_wdata_ff};
	endtask : ab

	// ------------------------------------------------
	// Scenarios
	// ------------------------------------------------
	task automatic t_regs;
		#1;
		`CHK({some_hart_was_reset_ff, every_hart_was_reset_ff}, 2'b00)
		csr(1'b0, 12'h7a0, 32'h0);
		`CHK(cr, {2'b10, 32'h0000_0000})
		csr(1'b1, 12'h7a1, 32'hffff_ffff);
		csr(1'b0, 12'h7a1, 32'h0);
		`CHK(cr, {2'b10, 32'h2080_085f})
		csr(1'b1, 12'h7a1, 32'h0000_1080);
		csr(1'b0, 12'h7a1, 32'h0);
		`CHK(cr, {2'b10, 32'h2080_1080})
		csr(1'b1, 12'h7a2, 32'ha5a5_5a5a);
		csr(1'b0, 12'h7a2, 32'h0);
		`CHK(cr, {2'b10, 32'ha5a5_5a5a})
		csr(1'b1, 12'h7a0, 32'h3);
		csr(1'b1, 12'h7a0, 32'h4);
		csr(1'b0, 12'h7a0, 32'h0);
		`CHK(cr, {2'b10, 32'h0000_0003})
		csr(1'b1, 12'h7a1, 32'h0000_0800);
		csr(1'b0, 12'h7a1, 32'h0);
		`CHK(cr, {2'b10, 32'h2080_0000})
		csr(1'b0, 12'h7a4, 32'h0);
		`CHK(cr[33], 1'b0)
	endtask : t_regs

	task automatic t_exact;
		cfg(2'd0, 32'h0000_0041, 32'h0000_1000);
		acc(HBTU_LOAD, 2'd3, 2'd0, 32'h0000_1000);
		`CHK(tr, {8'hb3, 32'h0000_1000})
		acc(HBTU_LOAD, 2'd3, 2'd3, 32'h0000_0ffe);
		`CHK(tr, {8'hb3, 32'h0000_0ffe})
		acc(HBTU_STORE, 2'd3, 2'd0, 32'h0000_1000);
		`CHK(tr, 40'h0)
		acc(HBTU_LOAD, 2'd0, 2'd0, 32'h0000_1000);
		`CHK(tr, 40'h0)
		cfg(2'd0, 32'h0000_005b, 32'h0000_1000);
		acc(HBTU_FETCH, 2'd0, 2'd0, 32'h0000_1000);
		`CHK(tr, 40'h0)
		acc(HBTU_STORE, 2'd0, 2'd0, 32'h0000_1000);
		`CHK(tr, {8'hb3, 32'h0000_1000})
		acc(HBTU_STORE, 2'd1, 2'd0, 32'h0000_1000);
		`CHK(tr, {8'hb3, 32'h0000_1000})
		cfg(2'd0, 32'h0000_0044, 32'h0000_1000);
		acc(HBTU_FETCH, 2'd3, 2'd0, 32'h0000_1000);
		`CHK(tr, {8'hb3, 32'h0000_1000})
		cfg(2'd0, 32'h0000_1041, 32'h0000_1000);
		acc(HBTU_LOAD, 2'd3, 2'd0, 32'h0000_1000);
		`CHK(tr, {8'hc0, 32'h0})
		@(posedge clk_sys) dbg_mode <= 1'b1;
		acc(HBTU_LOAD, 2'd3, 2'd0, 32'h0000_1000);
		`CHK(tr, 40'h0)
		@(posedge clk_sys) dbg_mode <= 1'b0;
	endtask : t_exact

	task automatic t_pow2;
		cfg(2'd0, 32'h0000_00c1, 32'h0000_2003);
		acc(HBTU_LOAD, 2'd3, 2'd0, 32'h0000_2007);
		`CHK(tr, {8'hb3, 32'h0000_2007})
		acc(HBTU_LOAD, 2'd3, 2'd0, 32'h0000_2008);
		`CHK(tr, 40'h0)
		acc(HBTU_LOAD, 2'd3, 2'd1, 32'h0000_1ffe);
		`CHK(tr, 40'h0)
		acc(HBTU_LOAD, 2'd3, 2'd1, 32'h0000_1fff);
		`CHK(tr, {8'hb3, 32'h0000_1fff})
		cfg(2'd0, 32'h0000_00c1, 32'h3fff_ffff);
		acc(HBTU_LOAD, 2'd3, 2'd0, 32'h7000_0000);
		`CHK(tr, {8'hb3, 32'h7000_0000})
		acc(HBTU_LOAD, 2'd3, 2'd0, 32'h8000_0000);
		`CHK(tr, 40'h0)
	endtask : t_pow2

	task automatic t_chain;
		cfg(2'd0, 32'h0000_0941, 32'h0000_4000);
		cfg(2'd1, 32'h0000_01c1, 32'h0000_4010);
		acc(HBTU_LOAD, 2'd3, 2'd0, 32'h0000_4008);
		`CHK(tr, {8'hb3, 32'h0000_4008})
		acc(HBTU_LOAD, 2'd3, 2'd0, 32'h0000_4010);
		`CHK(tr, 40'h0)
		acc(HBTU_LOAD, 2'd3, 2'd0, 32'h0000_3ff0);
		`CHK(tr, 40'h0)
	endtask : t_chain

	task automatic t_owner;
		@(posedge clk_sys) dbg_mode <= 1'b1;
		cfg(2'd2, 32'h0800_0041, 32'h0);
		csr(1'b0, 12'h7a1, 32'h0);
		`CHK(cr, {2'b10, 32'h2880_0041})
		@(posedge clk_sys) dbg_mode <= 1'b0;
		csr(1'b0, 12'h7a1, 32'h0);
		`CHK(cr, {2'b11, 32'h0})
		csr(1'b1, 12'h7a2, 32'h0000_0001);
		`CHK(cr, {2'b11, 32'h0})
		@(posedge clk_sys) dbg_mode <= 1'b1;
		csr(1'b0, 12'h7a2, 32'h0);
		`CHK(cr, {2'b10, 32'h0})
		@(posedge clk_sys) dbg_mode <= 1'b0;
	endtask : t_owner

	task automatic t_dm;
		dm(1'b1, 1'b1, 12'h300, 32'h1111_1111);
		dm(1'b1, 1'b1, 12'h33c, 32'h2222_2222);
		dm(1'b1, 1'b1, 12'h340, 32'h3333_3333);
		dm(1'b0, 1'b1, 12'h300, 32'h0);
		`CHK(dr, {2'b10, 32'h1111_1111})
		dm(1'b0, 1'b1, 12'h33c, 32'h0);
		`CHK(dr, {2'b10, 32'h2222_2222})
		dm(1'b0, 1'b1, 12'h340, 32'h0);
		`CHK(dr, {2'b10, 32'h3333_3333})
		@(posedge clk_sys);
		dm_req <= '{1'b1, 1'b1, 1'b1, 12'h304, 32'h4444_4444};
		@(posedge clk_sys);
		dm_req <= '{1'b1, 1'b0, 1'b1, 12'h304, 32'h0000_0000};
		@(posedge clk_sys);
		dm_req.valid <= 1'b0;
		#1 dr = {dm_ack_ff, dm_err_ff, dm_rdata_ff};
		`CHK(dr, {2'b10, 32'h4444_4444})
		dm(1'b1, 1'b1, 12'h000, 32'hffff_ffff);
		dm(1'b0, 1'b1, 12'h000, 32'h0);
		`CHK(dr, {2'b10, 32'h0})
		dm(1'b1, 1'b0, 12'h300, 32'hdead_beef);
		`CHK(dr, {2'b11, 32'h0})
		dm(1'b0, 1'b1, 12'h300, 32'h0);
		`CHK(dr, {2'b10, 32'h1111_1111})
	endtask : t_dm

	task automatic t_abs;
		@(posedge clk_sys) hart_halted <= 1'b1;
		ab(1'b1, 16'h1005);
		`CHK(ar, {4'b1011, 5'd5, 32'h3333_3333})
		ab(1'b0, 16'h101f);
		`CHK(ar[40:37], 4'b1010)
		for (int i = 0; i < 10 && gpr_rvalid !== 1'b1; i++)
		begin
			@(posedge clk_sys);
			#1;
		end
		@(posedge clk_sys);
		dm(1'b0, 1'b1, 12'h340, 32'h0);
		`CHK(dr, {2'b10, 32'hc0de_001f})
		ab(1'b0, 16'h1020);
		`CHK(ar[40:37], 4'b0100)
		@(posedge clk_sys) hart_halted <= 1'b0;
		ab(1'b0, 16'h1000);
		`CHK(ar[40:37], 4'b0100)
	endtask : t_abs

	task automatic print_verdict;
		if (n_errors == 0 && checked > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : print_verdict

	initial
	begin
		repeat (8) @(posedge clk_sys);
		rst <= 1'b0;
		t_regs;
		t_exact;
		t_pow2;
		t_chain;
		t_owner;
		t_dm;
		t_abs;
		print_verdict;
	end

	initial
	begin
		repeat (20000) @(posedge clk_sys);
		n_errors++;
		print_verdict;
	end
endmodule : hbtu_top_tb
`default_nettype wire
